// ===== csp_regs.sv
// Indexed loop-parameter registers for the third pixel clock and the memory clock.
// How it works
// - Pixel parameters commit after ordered four-register write.
// - Reserved bits always read back zero.
// - Post-divisor codes 0..5 decode to 1..32; codes 6 and 7 decode to zero.
// - VCO bit picks loop divide 4 or 16.
// - Reference code picks 4, 1, 20 or 5.
// - Memory M register holds seven bits.
// - Memory N register holds seven bits.
// - Select zero runs memory clock at preset.
// - Select one follows programmed memory parameters.
// - Memory reference bit divides by 4 or 1.
`timescale 1ns/10ps
`default_nettype none
module csp_regs
  import csp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Index and data port, one-cycle strobes from the host interface
  input wire logic [7:0] reg_index,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Committed pixel clock 2 loop parameters
  output logic [9:0] pix2_m,
  output logic [9:0] pix2_n,
  output logic [5:0] pix2_post_div,
  output logic [4:0] pix2_vco_div,
  output logic [4:0] pix2_ref_div,
  output logic pix2_update,
  // Memory clock loop parameters
  output logic mem_use_programmed,
  output logic [6:0] mem_m,
  output logic [6:0] mem_n,
  output logic [5:0] mem_post_div,
  output logic [4:0] mem_ref_div
);
  logic [7:0] shadow_m_low;
  logic [7:0] shadow_n_low;
  logic [7:0] shadow_high;
  logic [7:0] pix2_div_sel;
  logic [7:0] mem_m_div;
  logic [7:0] mem_n_div;
  logic [7:0] mem_div_sel;
  csp_seq_type seq;
  csp_seq_type next_seq;
  logic commit;
  logic [5:0] dec_pix_post;
  logic [4:0] dec_pix_vco;
  logic [4:0] dec_pix_ref;
  logic [5:0] dec_mem_post;
  logic [4:0] dec_mem_ref;

  function automatic logic hit(input logic [7:0] idx);
    hit = wr_en && (reg_index == idx);
  endfunction

  // Written values land in shadows; the running settings move only on commit.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shadow_m_low <= CSP_RESET_BYTE;
      shadow_n_low <= CSP_RESET_BYTE;
      shadow_high <= CSP_RESET_BYTE;
      pix2_div_sel <= CSP_RESET_BYTE;
    end
    else
    begin
      if (hit(CSP_IDX_PIX2_M_LOW))
        shadow_m_low <= wr_data;
      if (hit(CSP_IDX_PIX2_N_LOW))
        shadow_n_low <= wr_data;
      if (hit(CSP_IDX_PIX2_MN_HIGH))
        shadow_high <= wr_data & 8'h33;
      if (hit(CSP_IDX_PIX2_DIV_SEL))
        pix2_div_sel <= wr_data & CSP_PIX2_DIV_SEL_MASK;
    end
  end

  always_comb
  begin
    next_seq = seq;
    commit = 1'b0;
    if (wr_en)
    begin
      case (reg_index)
        CSP_IDX_PIX2_M_LOW: next_seq = CSP_SEQ_GOT_M;
        CSP_IDX_PIX2_N_LOW: next_seq = (seq == CSP_SEQ_GOT_M) ? CSP_SEQ_GOT_N : CSP_SEQ_IDLE;
        CSP_IDX_PIX2_MN_HIGH: next_seq = (seq == CSP_SEQ_GOT_N) ? CSP_SEQ_GOT_HIGH : CSP_SEQ_IDLE;
        CSP_IDX_PIX2_DIV_SEL:
        begin
          commit = (seq == CSP_SEQ_GOT_HIGH);
          next_seq = CSP_SEQ_IDLE;
        end
        default: next_seq = seq;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      seq <= CSP_SEQ_IDLE;
    else
      seq <= next_seq;
  end

  csp_div_decode u_pix_dec
  (
    .sel(wr_data & CSP_PIX2_DIV_SEL_MASK),
    .is_memory(1'b0),
    .post_div(dec_pix_post),
    .vco_div(dec_pix_vco),
    .ref_div(dec_pix_ref)
  );

  csp_div_decode u_mem_dec
  (
    .sel(wr_data & CSP_MEM_DIV_SEL_MASK),
    .is_memory(1'b1),
    .post_div(dec_mem_post),
    .vco_div(),
    .ref_div(dec_mem_ref)
  );

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pix2_m <= 10'h000;
      pix2_n <= 10'h000;
      pix2_post_div <= 6'h01;
      pix2_vco_div <= CSP_VCO_DIV_LO;
      pix2_ref_div <= CSP_REF_DIV_00;
      pix2_update <= 1'b0;
    end
    else
    begin
      pix2_update <= commit;
      if (commit)
      begin
        pix2_m <= {shadow_high[1:0], shadow_m_low};
        pix2_n <= {shadow_high[5:4], shadow_n_low};
        pix2_post_div <= dec_pix_post;
        pix2_vco_div <= dec_pix_vco;
        pix2_ref_div <= dec_pix_ref;
      end
    end
  end

  // Software is expected to drop the select bit before touching M, N or the divisors,
  // so the hardware accepts those writes at any time without guarding them.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_m_div <= CSP_RESET_BYTE;
      mem_n_div <= CSP_RESET_BYTE;
      mem_div_sel <= CSP_RESET_BYTE;
      mem_m <= 7'h00;
      mem_n <= 7'h00;
      mem_post_div <= 6'h01;
      mem_ref_div <= CSP_REF_DIV_00;
      mem_use_programmed <= 1'b0;
    end
    else
    begin
      if (hit(CSP_IDX_MEM_M_DIV))
      begin
        mem_m_div <= wr_data & CSP_MN_MASK;
        mem_m <= wr_data[6:0];
      end
      if (hit(CSP_IDX_MEM_N_DIV))
      begin
        mem_n_div <= wr_data & CSP_MN_MASK;
        mem_n <= wr_data[6:0];
      end
      if (hit(CSP_IDX_MEM_DIV_SEL))
      begin
        mem_div_sel <= wr_data & CSP_MEM_DIV_SEL_MASK;
        mem_post_div <= dec_mem_post;
        mem_ref_div <= dec_mem_ref;
        mem_use_programmed <= wr_data[CSP_MEM_SEL_BIT];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data <= CSP_RESET_BYTE;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_en;
      if (rd_en)
      begin
        case (reg_index)
          CSP_IDX_PIX2_DIV_SEL: rd_data <= pix2_div_sel;
          CSP_IDX_MEM_M_DIV: rd_data <= mem_m_div;
          CSP_IDX_MEM_N_DIV: rd_data <= mem_n_div;
          CSP_IDX_MEM_DIV_SEL: rd_data <= mem_div_sel;
          default: rd_data <= CSP_RESET_BYTE;
        endcase
      end
    end
  end

  // Checks next to the logic.
  sequence s_m_then_n;
    wr_en && reg_index == CSP_IDX_PIX2_M_LOW ##1 wr_en && reg_index == CSP_IDX_PIX2_N_LOW;
  endsequence

  property p_commit_only_from_high;
    @(posedge mclk) disable iff (!rst_n)
      pix2_update |-> $past(seq) == CSP_SEQ_GOT_HIGH && $past(reg_index) == CSP_IDX_PIX2_DIV_SEL;
  endproperty
  a_commit_only_from_high: assert property (p_commit_only_from_high) else $error("commit without order");

  property p_full_sequence_commits;
    @(posedge mclk) disable iff (!rst_n)
      s_m_then_n ##1 (wr_en && reg_index == CSP_IDX_PIX2_MN_HIGH)
      ##1 (wr_en && reg_index == CSP_IDX_PIX2_DIV_SEL) |=> pix2_update;
  endproperty
  a_full_sequence_commits: assert property (p_full_sequence_commits) else $error("ordered write lost");

  property p_hold_without_commit;
    @(posedge mclk) disable iff (!rst_n)
      !pix2_update |-> $stable(pix2_m) && $stable(pix2_n) && $stable(pix2_post_div)
      && $stable(pix2_vco_div) && $stable(pix2_ref_div);
  endproperty
  a_hold_without_commit: assert property (p_hold_without_commit) else $error("pixel moved");

  property p_reserved_zero;
    @(posedge mclk) disable iff (!rst_n)
      pix2_div_sel[7] == 1'b0 && pix2_div_sel[3] == 1'b0 && mem_m_div[7] == 1'b0
      && mem_n_div[7] == 1'b0 && mem_div_sel[3:1] == 3'b000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_read_echo;
    @(posedge mclk) disable iff (!rst_n)
      rd_en && reg_index == CSP_IDX_MEM_DIV_SEL |=> rd_valid && rd_data == $past(mem_div_sel);
  endproperty
  a_read_echo: assert property (p_read_echo) else $error("select readback wrong");

  property p_mem_m_write;
    @(posedge mclk) disable iff (!rst_n)
      wr_en && reg_index == CSP_IDX_MEM_M_DIV |=> mem_m == $past(wr_data[6:0]);
  endproperty
  a_mem_m_write: assert property (p_mem_m_write) else $error("memory M not taken");

  property p_mem_n_write;
    @(posedge mclk) disable iff (!rst_n)
      wr_en && reg_index == CSP_IDX_MEM_N_DIV |=> mem_n == $past(wr_data[6:0]);
  endproperty
  a_mem_n_write: assert property (p_mem_n_write) else $error("memory N not taken");

  property p_mem_select;
    @(posedge mclk) disable iff (!rst_n)
      wr_en && reg_index == CSP_IDX_MEM_DIV_SEL
      |=> mem_use_programmed == $past(wr_data[CSP_MEM_SEL_BIT]);
  endproperty
  a_mem_select: assert property (p_mem_select) else $error("memory select mismatch");

  property p_mem_ref;
    @(posedge mclk) disable iff (!rst_n)
      wr_en && reg_index == CSP_IDX_MEM_DIV_SEL
      |=> mem_ref_div == ($past(wr_data[0]) ? CSP_REF_DIV_01 : CSP_REF_DIV_00);
  endproperty
  a_mem_ref: assert property (p_mem_ref) else $error("memory reference wrong");

  property p_break_restarts;
    @(posedge mclk) disable iff (!rst_n)
      seq == CSP_SEQ_GOT_M && wr_en && reg_index == CSP_IDX_PIX2_MN_HIGH |=> seq == CSP_SEQ_IDLE;
  endproperty
  a_break_restarts: assert property (p_break_restarts) else $error("sequence not restarted");
endmodule
`default_nettype wire

// ===== csp_pkg.sv
// Shared constants for the clock synthesizer parameter registers.
`default_nettype none
package csp_pkg;
  localparam logic [7:0] CSP_IDX_PIX2_M_LOW = 8'hC8;
  localparam logic [7:0] CSP_IDX_PIX2_N_LOW = 8'hC9;
  localparam logic [7:0] CSP_IDX_PIX2_MN_HIGH = 8'hCA;
  localparam logic [7:0] CSP_IDX_PIX2_DIV_SEL = 8'hCB;
  localparam logic [7:0] CSP_IDX_MEM_M_DIV = 8'hCC;
  localparam logic [7:0] CSP_IDX_MEM_N_DIV = 8'hCD;
  localparam logic [7:0] CSP_IDX_MEM_DIV_SEL = 8'hCE;
  localparam logic [7:0] CSP_PIX2_DIV_SEL_MASK = 8'h77;
  localparam logic [7:0] CSP_MN_MASK = 8'h7F;
  localparam logic [7:0] CSP_MEM_DIV_SEL_MASK = 8'hF1;
  localparam logic [7:0] CSP_RESET_BYTE = 8'h00;
  localparam int CSP_POST_LSB = 4;
  localparam int CSP_VCO_BIT = 2;
  localparam int CSP_MEM_SEL_BIT = 7;
  localparam logic [5:0] CSP_POST_RESERVED = 6'h00;
  localparam logic [4:0] CSP_VCO_DIV_LO = 5'h04;
  localparam logic [4:0] CSP_VCO_DIV_HI = 5'h10;
  localparam logic [4:0] CSP_REF_DIV_00 = 5'h04;
  localparam logic [4:0] CSP_REF_DIV_01 = 5'h01;
  localparam logic [4:0] CSP_REF_DIV_10 = 5'h14;
  localparam logic [4:0] CSP_REF_DIV_11 = 5'h05;
  typedef enum logic [2:0]
  {
    CSP_SEQ_IDLE = 3'b000,
    CSP_SEQ_GOT_M = 3'b001,
    CSP_SEQ_GOT_N = 3'b010,
    CSP_SEQ_GOT_HIGH = 3'b011
  } csp_seq_type;
endpackage
`default_nettype wire

// ===== csp_div_decode.sv
// Decoder from a divisor-select byte to post, VCO and reference divide values.
`timescale 1ns/10ps
`default_nettype none
module csp_div_decode
  import csp_pkg::*;
(
  // Select byte and its flavour
  input wire logic [7:0] sel,
  input wire logic is_memory,
  // Decoded divide values
  output logic [5:0] post_div,
  output logic [4:0] vco_div,
  output logic [4:0] ref_div
);
  always_comb
  begin
    case (sel[6:4])
      3'b000: post_div = 6'h01;
      3'b001: post_div = 6'h02;
      3'b010: post_div = 6'h04;
      3'b011: post_div = 6'h08;
      3'b100: post_div = 6'h10;
      3'b101: post_div = 6'h20;
      default: post_div = CSP_POST_RESERVED;
    endcase
  end

  always_comb
  begin
    // The memory synthesizer has no VCO loop select, so it reads as the low value.
    if (!is_memory && sel[CSP_VCO_BIT])
      vco_div = CSP_VCO_DIV_HI;
    else
      vco_div = CSP_VCO_DIV_LO;
  end

  always_comb
  begin
    if (is_memory)
      ref_div = sel[0] ? CSP_REF_DIV_01 : CSP_REF_DIV_00;
    else
    begin
      case (sel[1:0])
        2'b00: ref_div = CSP_REF_DIV_00;
        2'b01: ref_div = CSP_REF_DIV_01;
        2'b10: ref_div = CSP_REF_DIV_10;
        default: ref_div = CSP_REF_DIV_11;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== csp_regs_tb_top.sv
// Self-checking testbench for the clock synthesizer parameter registers.
`timescale 1ns/10ps
`default_nettype none
module csp_regs_tb_top;
  import csp_pkg::*;
  logic mclk;
  logic rst_n;
  logic [7:0] reg_index;
  logic [7:0] wr_data;
  logic wr_en;
  logic rd_en;
  logic [7:0] rd_data;
  logic rd_valid;
  logic [9:0] pix2_m;
  logic [9:0] pix2_n;
  logic [5:0] pix2_post_div;
  logic [4:0] pix2_vco_div;
  logic [4:0] pix2_ref_div;
  logic pix2_update;
  logic mem_use_programmed;
  logic [6:0] mem_m;
  logic [6:0] mem_n;
  logic [5:0] mem_post_div;
  logic [4:0] mem_ref_div;
  integer seed = 64;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [7:0] cm, cn, ch, cd, ce;
  logic [31:0] r;

  csp_regs i_dut (.mclk(mclk), .rst_n(rst_n), .reg_index(reg_index), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid),
    .pix2_m(pix2_m), .pix2_n(pix2_n), .pix2_post_div(pix2_post_div),
    .pix2_vco_div(pix2_vco_div), .pix2_ref_div(pix2_ref_div), .pix2_update(pix2_update),
    .mem_use_programmed(mem_use_programmed), .mem_m(mem_m), .mem_n(mem_n),
    .mem_post_div(mem_post_div), .mem_ref_div(mem_ref_div));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Codes above five are reserved and the design reports them as zero.
  function automatic logic [5:0] post_of(input logic [2:0] c);
    return (c > 3'h5) ? 6'h00 : 6'(32'h1 << c);
  endfunction

  function automatic logic [4:0] ref_of(input logic [1:0] c);
    return (c == 2'h0) ? 5'h04 : (c == 2'h1) ? 5'h01 : (c == 2'h2) ? 5'h14 : 5'h05;
  endfunction

  task automatic final_report();
    if (n_mismatch == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Strobes stay up between back-to-back requests so no signal is set twice at one time.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    rd_en = 1'b0;
    reg_index = idx;
    wr_data = d;
    wr_en = 1'b1;
    @(posedge mclk);
    #1;
  endtask

  task automatic idle();
    wr_en = 1'b0;
    rd_en = 1'b0;
    @(posedge mclk);
    #1;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    wr_en = 1'b0;
    reg_index = idx;
    rd_en = 1'b1;
    @(posedge mclk);
    #1;
    chk("rd_valid", rd_valid, 16'h1);
    chk("rd_data", rd_data, exp);
  endtask

  task automatic chk_pix();
    chk("pix2_m", pix2_m, {ch[1:0], cm});
    chk("pix2_n", pix2_n, {ch[5:4], cn});
    chk("pix2_post_div", pix2_post_div, post_of(cd[6:4]));
    chk("pix2_vco_div", pix2_vco_div, cd[2] ? 5'h10 : 5'h04);
    chk("pix2_ref_div", pix2_ref_div, ref_of(cd[1:0]));
  endtask

  task automatic chk_mem();
    chk("mem_use_programmed", mem_use_programmed, ce[7]);
    chk("mem_post_div", mem_post_div, post_of(ce[6:4]));
    chk("mem_ref_div", mem_ref_div, ce[0] ? 5'h01 : 5'h04);
  endtask

  // Four writes; the committed copy moves only when a full ordered sequence is expected.
  task automatic seq(input logic [31:0] idx, input logic [31:0] d, input logic commit);
    for (int k = 3; k >= 0; k--)
      wr(idx[8*k +: 8], d[8*k +: 8]);
    if (commit)
      {cm, cn, ch, cd} = d;
    chk("pix2_update", pix2_update, commit);
    chk_pix();
    rd(CSP_IDX_PIX2_DIV_SEL, d[7:0] & 8'h77);
    idle();
  endtask

  task automatic after_reset();
    {cm, cn, ch, cd, ce} = 40'h0;
    chk_pix();
    chk_mem();
    chk("pix2_update", pix2_update, 16'h0);
    chk("mem_m", mem_m, 16'h0);
    chk("mem_n", mem_n, 16'h0);
    chk("rd_valid", rd_valid, 16'h0);
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    reg_index = 8'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    after_reset();
    for (int i = 0; i < 64; i++)
    begin
      r = $random(seed);
      seq(32'hC8C9CACB, {r[23:0] | 24'h800000, r[31], 3'(i), r[27], 3'(i >> 3)}, 1'b1);
    end
    wr(CSP_IDX_PIX2_M_LOW, 8'h5A);
    rd(CSP_IDX_MEM_DIV_SEL, 8'h00);
    r = $random(seed);
    seq(32'hC8C9CACB, r, 1'b1);
    r = $random(seed);
    seq(32'hC8C8C9CB, r, 1'b0);
    wr(CSP_IDX_PIX2_M_LOW, 8'hA5);
    r = $random(seed);
    seq(32'hCAC9CACB, r, 1'b0);
    seq(32'hC8C9C9CB, ~r, 1'b0);
    for (int i = 0; i < 16; i++)
    begin
      r = $random(seed);
      ce[7] = 1'b0;
      wr(CSP_IDX_MEM_DIV_SEL, ce);
      chk_mem();
      wr(CSP_IDX_MEM_M_DIV, r[7:0]);
      wr(CSP_IDX_MEM_N_DIV, r[15:8]);
      ce = {~r[20] | i[3], 3'(i), r[19:16]};
      wr(CSP_IDX_MEM_DIV_SEL, ce);
      chk_mem();
      chk("mem_m", mem_m, r[6:0]);
      chk("mem_n", mem_n, r[14:8]);
      rd(CSP_IDX_MEM_M_DIV, r[7:0] & 8'h7F);
      rd(CSP_IDX_MEM_N_DIV, r[15:8] & 8'h7F);
      rd(CSP_IDX_MEM_DIV_SEL, ce & 8'hF1);
      idle();
      chk("rd_valid", rd_valid, 16'h0);
    end
    wr(8'hCF, 8'hFF);
    wr(8'h00, 8'hFF);
    rd(8'hCF, 8'h00);
    rd(CSP_IDX_PIX2_M_LOW, 8'h00);
    rd(CSP_IDX_MEM_DIV_SEL, ce & 8'hF1);
    idle();
    rst_n = 1'b0;
    @(posedge mclk);
    #1;
    after_reset();
    rst_n = 1'b1;
    rd(CSP_IDX_PIX2_DIV_SEL, 8'h00);
    idle();
    final_report();
  end
endmodule
`default_nettype wire
